// ### hw/cep_pkg.sv
package cep_pkg;

	// ********************************************************
	// Event levels
	// ********************************************************
	localparam int NLVL = 16;
	localparam int NGEN = 9;
	localparam logic [3:0] LVL_EMU = 4'h0;
	localparam logic [3:0] LVL_RST = 4'h1;
	localparam logic [3:0] LVL_NMI = 4'h2;
	localparam logic [3:0] LVL_EXC = 4'h3;
	localparam logic [3:0] LVL_GEN_LO = 4'h7;
	localparam logic [15:0] ALWAYS_ON = 16'h000f;
	localparam logic [15:0] RSV_BITS = 16'h0010;
	localparam logic [15:0] GEN_BITS = 16'hff80;
	localparam logic [15:0] INT_CLASS = 16'hffe2;

	// ********************************************************
	// Register map and reset values
	// ********************************************************
	localparam int REG_AW = 8;
	localparam int REG_DW = 16;
	localparam logic [7:0] OFS_LATCH = 8'h00;
	localparam logic [7:0] OFS_UNMASK = 8'h04;
	localparam logic [7:0] OFS_PEND = 8'h08;
	localparam logic [7:0] OFS_CTRL = 8'h0c;
	localparam logic [7:0] OFS_RAISE = 8'h10;
	localparam logic [15:0] UNMASK_RST = 16'h0000;
	localparam logic [15:0] PEND_AFTER_RST = 16'h0002;
	localparam logic GEN_EN_RST = 1'b1;
	localparam int CTRL_GEN_EN_BIT = 0;

	// ********************************************************
	// Types
	// ********************************************************
	typedef enum logic [1:0] {
		CEP_RET_EMU,
		CEP_RET_NMI,
		CEP_RET_EXC,
		CEP_RET_INT
	} cep_ret_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} cep_bus_t;

	typedef struct packed {
		logic valid;
		logic [3:0] level;
		logic save_state;
	} cep_disp_t;

endpackage : cep_pkg

// ### hw/cep_core_event_stage.sv
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ns
// Overview of operation
// - Highest pending priority always wins
// - Nested service; higher preempts lower handler
// - Emulation event enters emulation mode
// - Reset event resets the whole processor
// - Nonmaskable from watchdog or dedicated pin
// - Exceptions taken before offending instruction completes
// - Interrupts from pins, peripherals, software
// - Per-type return address and return command
// - Every dispatch requests state save
// - Peripheral interrupts arrive via the router
// - Nine general inputs, levels 7 to 15
// - Emulation 0, reset 1, nonmaskable 2, exception 3
// - Level 4 reserved; hardware 5, timer 6
// - General 7 to 14 at own level
// - General 15 is lowest, level 15
// - Two-cycle edge detect sets latch, pend clears
// - Unmask bit gates service, latch may stay
// - Edge to pending takes three cycles minimum

module cep_core_event_stage #(
	parameter int ADDR_W = 32
) (
	input logic clk,
	input logic nrst,
	input cep_pkg::cep_bus_t bus,
	output logic [cep_pkg::REG_DW-1:0] rdata,
	input logic emu_req,
	input logic rst_req,
	input logic nmi_pin,
	input logic wdog_nmi,
	input logic exc_req,
	input logic hw_err,
	input logic core_tmr,
	input logic [cep_pkg::NGEN-1:0] gen_irq,
	input logic [ADDR_W-1:0] pc_now,
	input logic ret_req,
	input cep_pkg::cep_ret_t ret_kind,
	output cep_pkg::cep_disp_t dispatch,
	output logic resume_valid,
	output logic [ADDR_W-1:0] resume_addr,
	output logic emu_mode,
	output logic core_reset_req,
	output logic [cep_pkg::NLVL-1:0] active_nesting_vector
);

	// ********************************************************
	// Elaboration checks
	// ********************************************************
	if (ADDR_W < 1) begin : g_bad_width
		$error("ADDR_W must be at least 1");
	end

	// ********************************************************
	// Helpers
	// ********************************************************
	function automatic logic [3:0] cep_first(input logic [15:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 15; i >= 0; i--) begin
			if (v[i]) begin
				r = i[3:0];
			end
		end
		return r;
	endfunction : cep_first

	function automatic logic [15:0] cep_bit(input logic [3:0] l);
		return 16'h0001 << l;
	endfunction : cep_bit

	// ********************************************************
	// State
	// ********************************************************
	logic [15:0] edge_now;
	logic [15:0] edge_old;
	logic [15:0] latch;
	logic [15:0] unmask;
	logic [15:0] pending;
	logic gen_en;
	logic [ADDR_W-1:0] ret_addr [4];

	// ********************************************************
	// Decode and selection
	// ********************************************************
	wire logic dec_latch = bus.addr == cep_pkg::OFS_LATCH;
	wire logic dec_unmask = bus.addr == cep_pkg::OFS_UNMASK;
	wire logic dec_pend = bus.addr == cep_pkg::OFS_PEND;
	wire logic dec_ctrl = bus.addr == cep_pkg::OFS_CTRL;
	wire logic dec_raise = bus.addr == cep_pkg::OFS_RAISE;
	wire logic nmi_any = nmi_pin | wdog_nmi;
	wire logic [15:0] raw_evt;
	wire logic [15:0] rise;
	wire logic [15:0] unmask_eff;
	wire logic [15:0] cand;
	wire logic [3:0] sel_lvl;
	wire logic [3:0] pend_top;
	wire logic sel_valid;
	wire logic take_rst;
	wire logic [15:0] take_bit;
	wire logic [15:0] soft_set;
	wire logic [15:0] exc_set;
	wire logic [15:0] writable;
	wire logic [15:0] latch_wr_val;
	wire logic [15:0] sets;
	wire logic [15:0] next_latch;
	wire logic [15:0] int_open;
	wire logic [15:0] ret_hit;
	wire logic [15:0] ret_clr;
	wire logic [15:0] next_pending;
	wire logic [15:0] rd_mux;
	wire cep_pkg::cep_ret_t sel_kind;
	wire logic [ADDR_W-1:0] exc_addr = ret_addr[cep_pkg::CEP_RET_EXC];

	// Router feeds levels 7..15; level 4 and exception never edge-latched
	assign raw_evt = {gen_irq, core_tmr, hw_err, 1'b0, 1'b0,
		nmi_any, rst_req, emu_req};
	assign rise = edge_now & ~edge_old;

	// Dedicated levels cannot be masked; reserved level never serviced
	assign unmask_eff = (unmask | cep_pkg::ALWAYS_ON)
		& ~cep_pkg::RSV_BITS
		& (gen_en ? 16'hffff : ~cep_pkg::GEN_BITS);
	assign cand = latch & unmask_eff;

	// Lowest index is highest priority, so level equals bit number
	assign sel_lvl = cep_first(cand);
	assign pend_top = cep_first(pending);
	assign sel_valid = (|cand)
		&& (pending == 16'h0000 || sel_lvl < pend_top);
	assign take_bit = sel_valid ? cep_bit(sel_lvl) : 16'h0000;
	assign take_rst = sel_valid && sel_lvl == cep_pkg::LVL_RST;

	// Software raise covers any level but the reserved one
	assign soft_set = (bus.wr && dec_raise)
		? (bus.wdata & ~cep_pkg::RSV_BITS) : 16'h0000;
	// Exception latches at once so it wins before the instruction retires
	assign exc_set = exc_req
		? cep_bit(cep_pkg::LVL_EXC) : 16'h0000;

	// Latch writes land only on masked bits
	assign writable = ~unmask_eff;
	assign latch_wr_val = (bus.wr && dec_latch)
		? ((latch & ~writable) | (bus.wdata & writable)) : latch;
	assign sets = rise | soft_set | exc_set;
	// New sets win over the clear caused by dispatch
	assign next_latch = ((take_rst ? 16'h0000 : (latch_wr_val & ~take_bit))
		| sets) & ~cep_pkg::RSV_BITS;

	// Return from interrupt closes the innermost open interrupt level
	assign int_open = pending & cep_pkg::INT_CLASS;
	assign ret_hit = (ret_kind == cep_pkg::CEP_RET_EMU)
		? cep_bit(cep_pkg::LVL_EMU)
		: (ret_kind == cep_pkg::CEP_RET_NMI)
		? cep_bit(cep_pkg::LVL_NMI)
		: (ret_kind == cep_pkg::CEP_RET_EXC)
		? cep_bit(cep_pkg::LVL_EXC)
		: (cep_bit(cep_first(int_open)) & int_open);
	assign ret_clr = ret_req ? (ret_hit & pending) : 16'h0000;
	// Reset event wipes all nesting and restarts from the reset level
	assign next_pending = take_rst ? cep_pkg::PEND_AFTER_RST
		: ((pending & ~ret_clr) | take_bit);

	assign sel_kind = (sel_lvl == cep_pkg::LVL_EMU) ? cep_pkg::CEP_RET_EMU
		: (sel_lvl == cep_pkg::LVL_NMI) ? cep_pkg::CEP_RET_NMI
		: (sel_lvl == cep_pkg::LVL_EXC) ? cep_pkg::CEP_RET_EXC
		: cep_pkg::CEP_RET_INT;

	assign rd_mux = dec_latch ? latch
		: dec_unmask ? ((unmask | cep_pkg::ALWAYS_ON) & ~cep_pkg::RSV_BITS)
		: dec_pend ? pending
		: dec_ctrl ? {15'h0000, gen_en}
		: 16'h0000;

	// Router watches this as its acknowledgement
	assign active_nesting_vector = pending;

	// ********************************************************
	// Edge detection
	// ********************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			edge_now <= 16'h0000;
			edge_old <= 16'h0000;
		end else begin
			edge_now <= raw_evt;
			edge_old <= edge_now;
		end
	end

	// ********************************************************
	// Latch, nesting and control
	// ********************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			latch <= 16'h0000;
			pending <= 16'h0000;
		end else begin
			latch <= next_latch;
			pending <= next_pending;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			unmask <= cep_pkg::UNMASK_RST;
			gen_en <= cep_pkg::GEN_EN_RST;
		end else if (bus.wr && dec_unmask) begin
			unmask <= bus.wdata & ~cep_pkg::RSV_BITS & ~cep_pkg::ALWAYS_ON;
		end else if (bus.wr && dec_ctrl) begin
			gen_en <= bus.wdata[cep_pkg::CTRL_GEN_EN_BIT];
		end
	end

	// ********************************************************
	// Dispatch to the pipeline
	// ********************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dispatch <= '0;
			core_reset_req <= 1'b0;
		end else begin
			dispatch.valid <= sel_valid;
			dispatch.level <= sel_lvl;
			dispatch.save_state <= sel_valid;
			core_reset_req <= take_rst;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			emu_mode <= 1'b0;
		end else if (sel_valid && sel_lvl == cep_pkg::LVL_EMU) begin
			emu_mode <= 1'b1;
		end else if (ret_req && ret_kind == cep_pkg::CEP_RET_EMU) begin
			emu_mode <= 1'b0;
		end
	end

	// ********************************************************
	// Return addresses
	// ********************************************************
	// One slot per event type; nested interrupts share the slot, the
	// handler must stack it before unmasking deeper nesting
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int k = 0; k < 4; k++) begin
				ret_addr[k] <= '0;
			end
		end else if (sel_valid) begin
			ret_addr[sel_kind] <= pc_now;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			resume_valid <= 1'b0;
			resume_addr <= '0;
		end else begin
			resume_valid <= ret_req;
			resume_addr <= ret_req ? ret_addr[ret_kind] : '0;
		end
	end

	// ********************************************************
	// Register read port
	// ********************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= 16'h0000;
		end else begin
			rdata <= bus.rd ? rd_mux : 16'h0000;
		end
	end

	// ********************************************************
	// Checks
	// ********************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	chk_prio_win: assert property (
		sel_valid |-> (cand & (take_bit - 16'h0001)) == 16'h0000)
		else $error("higher candidate skipped");

	chk_nest_above: assert property (
		sel_valid |-> (pending & (take_bit | (take_bit - 16'h0001))) == 16'h0)
		else $error("dispatch not above active level");

	chk_pend_set: assert property (
		sel_valid |=> dispatch.valid && dispatch.save_state
		&& pending[dispatch.level])
		else $error("dispatch did not enter nesting");

	chk_latch_set: assert property (
		rise[7] |=> latch[7])
		else $error("edge not latched");

	chk_latch_clear: assert property (
		(sel_valid && sel_lvl == 4'h7 && !rise[7] && !bus.wr)
		|=> !latch[7] && pending[7])
		else $error("latch not cleared on entry");

	chk_gen_latency: assert property (
		($rose(gen_irq[0]) && !latch[7] && !pending[7] && !bus.wr)
		|=> !pending[7] ##1 !pending[7])
		else $error("general event entered too early");

	chk_mask_gate: assert property (
		sel_valid |-> unmask_eff[sel_lvl] && sel_lvl != 4'h4)
		else $error("masked or reserved level dispatched");

	chk_emu_enter: assert property (
		(sel_valid && sel_lvl == 4'h0) |=> emu_mode && dispatch.level == 4'h0)
		else $error("emulation mode not entered");

	chk_reset_all: assert property (
		take_rst |=> core_reset_req && pending == 16'h0002)
		else $error("reset event did not reset nesting");

	chk_nmi_path: assert property (
		($rose(nmi_any) && !latch[2] && !pending[2]) |-> ##2 latch[2])
		else $error("nonmaskable source lost");

	chk_exc_take: assert property (
		exc_req |=> latch[3] || pending[3])
		else $error("exception not latched");

	chk_ret_clear: assert property (
		(ret_req && ret_kind == cep_pkg::CEP_RET_EXC && pending[3]
		&& !(sel_valid && sel_lvl == 4'h3))
		|=> resume_valid && !pending[3] && resume_addr == $past(exc_addr))
		else $error("exception return failed");

	chk_soft_raise: assert property (
		(bus.wr && dec_raise && bus.wdata[14]) |=> latch[14] || pending[14])
		else $error("software raise lost");

	chk_gen_block: assert property (
		(sel_valid && !gen_en) |-> sel_lvl < cep_pkg::LVL_GEN_LO)
		else $error("general level dispatched while disabled");

endmodule : cep_core_event_stage

// ### tb/cep_router_model.sv
`timescale 1ns/1ns
// ****
// Router stand-in
// ****
module cep_router_model (
	input wire logic [8:0] src_a,
	input wire logic [8:0] src_b,
	output logic [8:0] gen_irq
);
	// Sources sharing one input merge; core sees one edge
	assign gen_irq = src_a | src_b;
endmodule : cep_router_model

// ### tb/tb_cep_core_event_stage.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end
module tb_cep_core_event_stage;
	// ****
	// Stimulus and wiring
	// ****
	logic clk = 1'b0;
	logic nrst = 1'b0;
	cep_pkg::cep_bus_t bus = '0;
	logic [15:0] rdata;
	logic [6:0] ev = 7'h00;
	logic [8:0] src_a = 9'h000;
	logic [8:0] src_b = 9'h000;
	logic [8:0] gen_irq;
	logic [31:0] pc_now = 32'h0;
	logic ret_req = 1'b0;
	cep_pkg::cep_ret_t ret_kind = cep_pkg::CEP_RET_INT;
	cep_pkg::cep_disp_t dispatch;
	logic resume_valid;
	logic [31:0] resume_addr;
	logic emu_mode;
	logic core_reset_req;
	logic [15:0] anv;
	logic [15:0] d;
	int failures = 0;
	int n_checks = 0;
	always #50 clk = ~clk;
	cep_router_model i_cep_router_model (.src_a(src_a), .src_b(src_b),
		.gen_irq(gen_irq));
	cep_core_event_stage i_cep_core_event_stage (.clk(clk), .nrst(nrst),
		.bus(bus), .rdata(rdata), .emu_req(ev[0]), .rst_req(ev[1]),
		.nmi_pin(ev[2]), .wdog_nmi(ev[4]), .exc_req(ev[3]), .hw_err(ev[5]),
		.core_tmr(ev[6]), .gen_irq(gen_irq), .pc_now(pc_now),
		.ret_req(ret_req), .ret_kind(ret_kind), .dispatch(dispatch),
		.resume_valid(resume_valid), .resume_addr(resume_addr),
		.emu_mode(emu_mode), .core_reset_req(core_reset_req),
		.active_nesting_vector(anv));
	// ****
	// Bus and event helpers
	// ****
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		bus <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk);
		bus <= '{a, v, 1'b1, 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask : wr
	task automatic kick(input logic [15:0] m, input logic [8:0] b);
		@(posedge clk);
		ev <= m[6:0];
		src_a <= m[15:7];
		src_b <= b;
	endtask : kick
	// One-cycle pulses: inputs drop at the first edge
	task automatic wd(input logic [3:0] lvl, input int lat);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			ev <= 7'h00;
			src_a <= 9'h000;
			src_b <= 9'h000;
			#1 n++;
		end while (dispatch.valid !== 1'b1 && n < 12);
		`CHK("level", lvl, dispatch.level)
		`CHK("save", 1'b1, dispatch.save_state)
		if (lat > 0) `CHK("latency", lat, n)
	endtask : wd
	task automatic quiet(input int k);
		repeat (k) begin
			@(posedge clk);
			ev <= 7'h00;
			src_a <= 9'h000;
			#1 `CHK("idle", 1'b0, dispatch.valid)
		end
	endtask : quiet
	task automatic ret(input cep_pkg::cep_ret_t k, input logic [15:0] p);
		@(posedge clk);
		ret_req <= 1'b1;
		ret_kind <= k;
		@(posedge clk);
		ret_req <= 1'b0;
		#1 `CHK("resume", 1'b1, resume_valid)
		`CHK("raddr", pc_now, resume_addr)
		`CHK("pend", p, anv)
	endtask : ret
	// ****
	// Scenarios
	// ****
	task automatic t_regs;
		if (anv[1] === 1'b1) ret(cep_pkg::CEP_RET_INT, 16'h0000);
		rd(cep_pkg::OFS_UNMASK);
		`CHK("unmask", 16'h000f, d)
		rd(cep_pkg::OFS_CTRL);
		`CHK("ctrl", 16'h0001, d)
		rd(8'h20);
		`CHK("unmapped", 16'h0000, d)
		wr(cep_pkg::OFS_UNMASK, 16'hffff);
		rd(cep_pkg::OFS_UNMASK);
		`CHK("reserved", 16'hffef, d)
		$display("test regs done");
	endtask : t_regs
	task automatic t_levels;
		logic [3:0] lv;
		cep_pkg::cep_ret_t k;
		for (int i = 0; i < 16; i++) begin
			lv = (i == 4) ? 4'h2 : i[3:0];
			k = (i == 0) ? cep_pkg::CEP_RET_EMU : (i == 2 || i == 4) ?
				cep_pkg::CEP_RET_NMI : (i == 3) ? cep_pkg::CEP_RET_EXC :
				cep_pkg::CEP_RET_INT;
			@(posedge clk);
			pc_now <= 32'h1000 + i;
			kick(16'h0001 << i, 9'h000);
			wd(lv, (i == 3) ? 2 : 3);
			if (i == 0) `CHK("emu", 1'b1, emu_mode)
			if (i == 1) `CHK("rst", 1'b1, core_reset_req)
			if (i > 0) `CHK("active", 16'h0001 << lv, anv)
			ret(k, 16'h0000);
			if (i == 0) `CHK("emu off", 1'b0, emu_mode)
		end
		$display("test levels done");
	endtask : t_levels
	task automatic t_prio;
		kick(16'h0080, 9'h004);
		wd(4'h7, 3);
		ret(cep_pkg::CEP_RET_INT, 16'h0000);
		wd(4'h9, 0);
		ret(cep_pkg::CEP_RET_INT, 16'h0000);
		$display("test prio done");
	endtask : t_prio
	task automatic t_nest;
		kick(16'h8000, 9'h000);
		wd(4'hf, 3);
		kick(16'h0020, 9'h000);
		wd(4'h5, 3);
		`CHK("nest", 16'h8020, anv)
		kick(16'h0100, 9'h000);
		quiet(6);
		ret(cep_pkg::CEP_RET_INT, 16'h8000);
		wd(4'h8, 0);
		`CHK("nest2", 16'h8100, anv)
		ret(cep_pkg::CEP_RET_INT, 16'h8000);
		ret(cep_pkg::CEP_RET_INT, 16'h0000);
		$display("test nest done");
	endtask : t_nest
	task automatic t_mask;
		wr(cep_pkg::OFS_UNMASK, 16'hff7f);
		kick(16'h0080, 9'h000);
		quiet(6);
		rd(cep_pkg::OFS_LATCH);
		`CHK("latched", 16'h0080, d)
		wr(cep_pkg::OFS_UNMASK, 16'hffff);
		wd(4'h7, 0);
		rd(cep_pkg::OFS_LATCH);
		`CHK("latch clr", 16'h0000, d)
		ret(cep_pkg::CEP_RET_INT, 16'h0000);
		$display("test mask done");
	endtask : t_mask
	// General levels held off while disabled; latch write only where masked
	task automatic t_gen;
		wr(cep_pkg::OFS_CTRL, 16'h0000);
		kick(16'h0208, 9'h000);
		wd(4'h3, 2);
		ret(cep_pkg::CEP_RET_EXC, 16'h0000);
		quiet(3);
		rd(cep_pkg::OFS_LATCH);
		`CHK("gen held", 16'h0200, d)
		wr(cep_pkg::OFS_LATCH, 16'h0020);
		quiet(3);
		rd(cep_pkg::OFS_LATCH);
		`CHK("latch wr", 16'h0000, d)
		wr(cep_pkg::OFS_CTRL, 16'h0001);
		quiet(3);
		rd(cep_pkg::OFS_PEND);
		`CHK("pend idle", 16'h0000, d)
		$display("test gen done");
	endtask : t_gen
	task automatic t_soft;
		wr(cep_pkg::OFS_RAISE, 16'h4010);
		wd(4'he, 1);
		rd(cep_pkg::OFS_PEND);
		`CHK("soft pend", 16'h4000, d)
		rd(cep_pkg::OFS_RAISE);
		`CHK("raise rd", 16'h0000, d)
		ret(cep_pkg::CEP_RET_INT, 16'h0000);
		$display("test soft done");
	endtask : t_soft
	// ****
	// Run control
	// ****
	task automatic report_and_stop;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		t_regs;
		t_levels;
		t_prio;
		t_nest;
		t_mask;
		t_gen;
		t_soft;
		report_and_stop;
	end
	// Tests need well under 1000 cycles; generous margin
	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		report_and_stop;
	end
endmodule : tb_cep_core_event_stage
